/* File: core/sweep_map.svh */
// register offsets, field positions and reset values of the sweep mode control block
`ifndef SWEEP_MAP_SVH
`define SWEEP_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_MODE      8'h00
`define OFS_BURST     8'h04
`define OFS_INTERVAL  8'h08
`define OFS_STEPS     8'h0C
`define OFS_CMD       8'h10
`define OFS_STATUS    8'h14

// ****************************************
// field positions
// ****************************************
`define MODE_LSB      2
`define MODE_MSB      9
`define CNT_W         16
`define UNIT_BIT      16
`define CMD_START     0
`define CMD_STOP      1

// ****************************************
// reset values and levels
// ****************************************
`define MODE_RST      8'h00
`define BURST_RST     17'h00010
`define INTERVAL_RST  17'h00040
`define STEPS_RST     8'h04
`define MIDSCALE      10'h200
`define SINE_PEAK     9'h1FF

`endif

/* File: core/sweep_pkg.sv */
// types shared by the sweep mode control block
`include "sweep_map.svh"

package sweep_pkg;

   // mode bits, msb first as they sit in the mode register
   typedef struct packed {
      logic waveform_shape_select;
      logic digital_out_enable;
      logic continuous_burst_select;
      logic burst_source_select;
      logic increment_source_select;
      logic sweep_saw_select;
      logic sync_pulse_select;
      logic sync_out_enable;
   } ctrl_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ON   = 3'b010,
      ST_MID  = 3'b100
   } state_t;

endpackage

/* File: core/sweep_burst_mode_control.sv */
// sweep and burst mode control with an ahb-lite register slave
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "sweep_map.svh"

module sweep_burst_mode_control
   import sweep_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [9:0]  phase_in,
   input  wire logic        phase_wrap,
   input  wire logic        trigger_pin,
   output logic [9:0]       analog_out_pair_code,
   output logic             square_digital_out,
   output logic             square_digital_out_oe_n,
   output logic             sync_out,
   output logic [7:0]       step_index,
   output logic             step_advance
);

   // ****************************************
   // functions
   // ****************************************
   function automatic logic unit_tick(input logic by_cycles, input logic wrap);
      return by_cycles ? wrap : 1'b1;
   endfunction

   function automatic logic reached(input logic [15:0] cnt, input logic [15:0] lim);
      return ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
   endfunction

   function automatic logic [9:0] tri_wave(input logic [9:0] p);
      return p[9] ? ~{p[8:0], 1'b0} : {p[8:0], 1'b0};
   endfunction

   function automatic logic [9:0] sine_wave(input logic [9:0] p);
      logic [18:0] prod;
      logic [8:0]  s;
      prod = {10'h000, p[8:0]} * (19'h00200 - {10'h000, p[8:0]});
      s    = (prod[18:7] > 12'h1FF) ? `SINE_PEAK : prod[15:7];
      return p[9] ? (`MIDSCALE - {1'b0, s}) : (`MIDSCALE + {1'b0, s});
   endfunction

   // ****************************************
   // ahb-lite slave
   // ****************************************
   logic        wr_q;
   logic [7:0]  waddr_q;
   logic [31:0] hrdata_q;
   ctrl_t       mode_q;
   logic [16:0] burst_q;
   logic [16:0] intv_q;
   logic [7:0]  steps_q;
   state_t      state_q;
   ctrl_t       act_q;
   logic [15:0] win_cnt_q;
   logic [15:0] bst_cnt_q;
   logic [7:0]  step_q;
   logic        dir_q;
   logic        sync_q;
   logic        adv_q;
   logic [9:0]  dac_q;
   logic        sq_q;
   logic        oe_n_q;
   logic        trig_s1;
   logic        trig_s2;
   logic        trig_s3;

   wire addr_ok   = hsel & hready & htrans[1];
   wire wr_mode   = wr_q & (waddr_q == `OFS_MODE);
   wire wr_burst  = wr_q & (waddr_q == `OFS_BURST);
   wire wr_intv   = wr_q & (waddr_q == `OFS_INTERVAL);
   wire wr_steps  = wr_q & (waddr_q == `OFS_STEPS);
   wire wr_cmd    = wr_q & (waddr_q == `OFS_CMD);
   wire start_p   = wr_cmd & hwdata[`CMD_START];
   wire stop_p    = wr_cmd & hwdata[`CMD_STOP];
   wire running   = state_q != ST_IDLE;

   // ****************************************
   // sweep decode
   // ****************************************
   wire ext_incr   = act_q.increment_source_select;
   wire ext_burst  = ext_incr & ~act_q.continuous_burst_select
                     & act_q.burst_source_select;
   wire trig_rise  = trig_s2 & ~trig_s3;
   wire win_tick   = unit_tick(intv_q[`UNIT_BIT], phase_wrap);
   wire bst_tick   = unit_tick(burst_q[`UNIT_BIT], phase_wrap);
   wire int_end    = win_tick & reached(win_cnt_q, intv_q[15:0]);
   wire win_end    = running & (ext_incr ? trig_rise : int_end);
   wire burst_end  = (state_q == ST_ON) & ~act_q.continuous_burst_select
                     & ~ext_burst & bst_tick
                     & reached(bst_cnt_q, burst_q[15:0]);
   wire burst_gate = ext_burst ? (running & trig_s2)
                               : (state_q == ST_ON);
   wire at_top     = step_q == steps_q;
   wire saw        = act_q.sweep_saw_select;
   wire last_step  = saw ? at_top : (dir_q ? (step_q == 8'h00)
                                           : (at_top & (steps_q == 8'h00)));
   wire sweep_done = win_end & last_step;
   wire [7:0] step_d = (~saw & (dir_q | at_top)) ? (step_q - 8'h01)
                                                 : (step_q + 8'h01);
   wire dir_d      = ~saw & (dir_q | at_top);
   wire eos_mode   = act_q.sync_out_enable & act_q.sync_pulse_select;
   wire sync_d     = act_q.sync_out_enable & (act_q.sync_pulse_select
                     ? (sweep_done | (sync_q & ~(start_p & ~running)))
                     : (win_end & ~last_step));
   wire [9:0] wave = act_q.waveform_shape_select ? sine_wave(phase_in)
                                                 : tri_wave(phase_in);
   wire [9:0] dac_d = burst_gate ? wave : `MIDSCALE;

   wire [31:0] rdata_d =
      (haddr[7:0] == `OFS_MODE)     ? {22'h000000, mode_q, 2'h0} :
      (haddr[7:0] == `OFS_BURST)    ? {15'h0000, burst_q} :
      (haddr[7:0] == `OFS_INTERVAL) ? {15'h0000, intv_q} :
      (haddr[7:0] == `OFS_STEPS)    ? {24'h000000, steps_q} :
      (haddr[7:0] == `OFS_STATUS)   ? {16'h0000, step_q, 4'h0, sync_q,
                                       burst_gate, dir_q, running} :
                                      32'h00000000;

   assign hreadyout               = 1'b1;
   assign hresp                   = 1'b0;
   assign hrdata                  = hrdata_q;
   assign analog_out_pair_code    = dac_q;
   assign square_digital_out      = sq_q;
   assign square_digital_out_oe_n = oe_n_q;
   assign sync_out                = sync_q;
   assign step_index              = step_q;
   assign step_advance            = adv_q;

   // ****************************************
   // register file
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q     <= 1'b0;
         waddr_q  <= 8'h00;
         hrdata_q <= 32'h00000000;
      end else begin
         wr_q     <= addr_ok & hwrite;
         waddr_q  <= haddr[7:0];
         hrdata_q <= (addr_ok & ~hwrite) ? rdata_d : 32'h00000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q  <= `MODE_RST;
         burst_q <= `BURST_RST;
         intv_q  <= `INTERVAL_RST;
         steps_q <= `STEPS_RST;
      end else begin
         if (wr_mode)  mode_q  <= hwdata[`MODE_MSB:`MODE_LSB];
         if (wr_burst) burst_q <= hwdata[16:0];
         if (wr_intv)  intv_q  <= hwdata[16:0];
         if (wr_steps) steps_q <= hwdata[7:0];
      end
   end

   // ****************************************
   // trigger pin synchroniser
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
      end else begin
         trig_s1 <= trigger_pin;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
      end
   end

   // ****************************************
   // sweep state machine
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         act_q   <= `MODE_RST;
         step_q  <= 8'h00;
         dir_q   <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_p) begin
                  state_q <= ST_ON;
                  act_q   <= mode_q;
                  step_q  <= 8'h00;
                  dir_q   <= 1'b0;
               end
            end
            ST_ON, ST_MID: begin
               if (stop_p) begin
                  state_q <= ST_IDLE;
               end else if (sweep_done) begin
                  state_q <= ST_IDLE;
                  step_q  <= 8'h00;
                  dir_q   <= 1'b0;
               end else if (win_end) begin
                  state_q <= ST_ON;
                  step_q  <= step_d;
                  dir_q   <= dir_d;
               end else if (burst_end) begin
                  state_q <= ST_MID;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_cnt_q <= 16'h0000;
         bst_cnt_q <= 16'h0000;
      end else if (!running || win_end) begin
         win_cnt_q <= 16'h0000;
         bst_cnt_q <= 16'h0000;
      end else begin
         if (!ext_incr && win_tick) win_cnt_q <= win_cnt_q + 16'h0001;
         if (state_q == ST_ON && bst_tick) bst_cnt_q <= bst_cnt_q + 16'h0001;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dac_q  <= `MIDSCALE;
         sq_q   <= 1'b0;
         oe_n_q <= 1'b1;
         sync_q <= 1'b0;
         adv_q  <= 1'b0;
      end else begin
         dac_q  <= dac_d;
         sq_q   <= dac_d[9];
         oe_n_q <= ~act_q.digital_out_enable;
         sync_q <= sync_d;
         adv_q  <= win_end & ~last_step;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_sweep_end;
      sweep_done & eos_mode;
   endsequence

   sequence s_new_sweep;
      ~running & start_p & eos_mode;
   endsequence

   sequence s_step_taken;
      win_end & ~last_step;
   endsequence

   a_tri_bypass: assert property (burst_gate & ~act_q.waveform_shape_select
      |=> dac_q == tri_wave($past(phase_in))) else $error("triangle path wrong");
   a_sine_path: assert property (burst_gate & act_q.waveform_shape_select
      |=> dac_q == sine_wave($past(phase_in))) else $error("sine path wrong");
   a_dout_hiz: assert property (~act_q.digital_out_enable
      |=> oe_n_q) else $error("digital out driven while disabled");
   a_cw_no_mid: assert property (act_q.continuous_burst_select
      |-> state_q != ST_MID) else $error("continuous mode went quiet");
   a_burst_len: assert property ($rose(state_q == ST_MID)
      |-> reached($past(bst_cnt_q), burst_q[15:0])) else $error("burst ended early");
   a_mid_level: assert property (state_q == ST_MID
      |=> dac_q == `MIDSCALE) else $error("no midscale after burst");
   a_ext_gate: assert property (running & ext_burst
      |-> burst_gate == trig_s2) else $error("external burst gate wrong");
   a_ext_step: assert property (running & ext_incr & ~trig_rise
      |=> $stable(step_q)) else $error("step without trigger");
   a_int_step: assert property (running & ~ext_incr & ~int_end
      |=> $stable(step_q)) else $error("step before interval");
   a_saw_wrap: assert property (running & saw & at_top & win_end & ~stop_p
      |=> step_q == 8'h00 && state_q == ST_IDLE) else $error("saw did not wrap");
   a_tri_down: assert property (running & ~saw & at_top & win_end & ~last_step
      & ~stop_p |=> dir_q && step_q == $past(step_q) - 8'h01) else $error("no down");
   a_sync_gate: assert property (~act_q.sync_out_enable
      |=> ~sync_q) else $error("sync while disabled");
   a_sync_hold: assert property (s_sweep_end |=> sync_q ##1 (sync_q ||
      $past(start_p))) else $error("end of sweep sync dropped");
   a_sync_drop: assert property (s_new_sweep |=> ~sync_q)
      else $error("sync not cleared at new sweep");
   a_mode_freeze: assert property (running |=> $stable(act_q))
      else $error("mode changed inside sweep");

   // ****************************************
   // step, output and bus checks
   // ****************************************
   a_ext_quiet: assert property (running & ext_burst & ~trig_s2
      |=> dac_q == `MIDSCALE) else $error("external burst not at midscale");
   a_adv_pulse: assert property (s_step_taken |=> adv_q)
      else $error("no advance pulse after step");
   a_adv_idle: assert property (~win_end |=> ~adv_q)
      else $error("advance pulse without step");
   a_oe_drive: assert property (act_q.digital_out_enable
      |=> ~oe_n_q) else $error("digital out not driven");
   a_sync_step: assert property (act_q.sync_out_enable & ~act_q.sync_pulse_select
      & win_end & ~last_step |=> sync_q) else $error("no sync on step");
   a_sync_single: assert property (act_q.sync_out_enable & ~act_q.sync_pulse_select
      & ~win_end |=> ~sync_q) else $error("sync pulse too long");
   a_idle_mid: assert property (~running |=> dac_q == `MIDSCALE)
      else $error("idle output not midscale");
   a_stop_idle: assert property (running & stop_p |=> ~running)
      else $error("stop ignored");
   a_rdata_idle: assert property (~(addr_ok & ~hwrite) |=> hrdata_q == 32'h00000000)
      else $error("read data outside data phase");
   a_steps_write: assert property (wr_steps |=> steps_q == $past(hwdata[7:0]))
      else $error("steps write lost");

endmodule

/* File: tb/trigger_host.sv */
// host model that drives the trigger pin with pulses of a chosen width
`timescale 1ns/10ps

module trigger_host (
   input  wire logic       hclk,
   input  wire logic       go,
   input  wire logic [7:0] width,
   output logic            trigger_pin
);
   logic [7:0] left_q;

   initial left_q = 8'h00;

   // one pulse per request, its width sets the burst length
   always @(posedge hclk) begin
      if (go) begin
         left_q <= width;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end

   // one rising edge per requested step, low between requests
   assign trigger_pin = (left_q != 8'h00);
endmodule

/* File: tb/test_sweep_burst_mode_control.sv */
// self-checking bench of the sweep and burst mode control block
`timescale 1ns/10ps

module test_sweep_burst_mode_control;
   import sweep_pkg::*;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [9:0]  phase_in, dac, dac_tri;
   logic        phase_wrap, trigger_pin, sq, oe_n, sync, adv, go;
   logic [7:0]  step, width;
   int          mismatches, samples_checked, cycles;

   sweep_burst_mode_control u_sweep_burst_mode_control (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_in(phase_in),
      .phase_wrap(phase_wrap), .trigger_pin(trigger_pin), .analog_out_pair_code(dac),
      .square_digital_out(sq), .square_digital_out_oe_n(oe_n), .sync_out(sync),
      .step_index(step), .step_advance(adv));

   trigger_host u_trigger_host (.hclk(hclk), .go(go), .width(width), .trigger_pin(trigger_pin));

   always #10 hclk = ~hclk;

   // ****************************************
   // compare and bus tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk(what, {31'h0, exp}, {31'h0, got});
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(what, e, r);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      chk_bit("oe_n", 1'b1, oe_n);
      chk("dac", 32'h200, {22'h0, dac});
      chk_bit("sync", 1'b0, sync);
      rd_chk("mode", 8'h00, 32'h0);
      rd_chk("burst", 8'h04, 32'h10);
      rd_chk("interval", 8'h08, 32'h40);
      rd_chk("steps", 8'h0C, 32'h4);
      rd_chk("unmapped", 8'h20, 32'h0);
      chk_bit("hresp", 1'b0, hresp);
      chk_bit("hready", 1'b1, hreadyout);
      $display("test reset done");
   endtask

   task automatic t_saw;
      int n;
      wr(8'h08, 32'h2);
      wr(8'h0C, 32'h1);
      wr(8'h00, 32'h39C);
      wr(8'h10, 32'h1);
      n = 0;
      while (step !== 8'h01 && n < 20) begin
         tick(1);
         n++;
      end
      chk_bit("step time", 1'b1, n >= 1 && n <= 4);
      chk_bit("advance", 1'b1, adv);
      chk_bit("oe_n on", 1'b0, oe_n);
      chk_bit("square", 1'b1, sq);
      n = 0;
      while (sync !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("saw end step", 32'h0, {24'h0, step});
      chk_bit("no final advance", 1'b0, adv);
      tick(10);
      chk_bit("sync held", 1'b1, sync);
      wr(8'h10, 32'h1);
      tick(2);
      chk_bit("sync cleared", 1'b0, sync);
      tick(20);
      $display("test saw done");
   endtask

   task automatic t_tri;
      logic [7:0] seq[$];
      logic [7:0] last;
      wr(8'h08, 32'h6);
      wr(8'h0C, 32'h2);
      wr(8'h00, 32'h88);
      wr(8'h10, 32'h1);
      wr(8'h00, 32'h190);
      tick(1);
      dac_tri = dac;
      chk_bit("cw wave", 1'b1, dac != 10'h200);
      last = step;
      repeat (60) begin
         tick(1);
         if (step !== last) seq.push_back(step);
         last = step;
      end
      chk("tri changes", 32'h4, seq.size());
      if (seq.size() == 4) chk("tri order", 32'h01020100, {seq[0], seq[1], seq[2], seq[3]});
      chk_bit("oe_n latched", 1'b1, oe_n);
      chk_bit("sync unused", 1'b0, sync);
      $display("test triangle done");
   endtask

   task automatic t_burst;
      wr(8'h08, 32'hA);
      wr(8'h04, 32'h3);
      wr(8'h0C, 32'h1);
      wr(8'h00, 32'h240);
      wr(8'h10, 32'h1);
      tick(2);
      chk_bit("burst wave", 1'b1, dac != 10'h200);
      chk_bit("shape differs", 1'b1, dac != dac_tri);
      tick(5);
      chk("burst midscale", 32'h200, {22'h0, dac});
      chk("burst step", 32'h0, {24'h0, step});
      wr(8'h10, 32'h2);
      wr(8'h08, 32'h14);
      wr(8'h04, 32'h10002);
      wr(8'h10, 32'h1);
      tick(6);
      chk_bit("burst by cycles", 1'b1, dac != 10'h200);
      @(posedge hclk);
      phase_wrap <= 1'b1;
      repeat (2) @(posedge hclk);
      phase_wrap <= 1'b0;
      tick(1);
      chk("cycle burst end", 32'h200, {22'h0, dac});
      wr(8'h10, 32'h2);
      $display("test burst done");
   endtask

   task automatic t_ext;
      wr(8'h0C, 32'h2);
      wr(8'h00, 32'h270);
      wr(8'h10, 32'h1);
      tick(20);
      chk("ext hold", 32'h0, {24'h0, step});
      chk("ext idle dac", 32'h200, {22'h0, dac});
      @(posedge hclk);
      go    <= 1'b1;
      width <= 8'h0A;
      @(posedge hclk);
      go    <= 1'b0;
      tick(5);
      chk("ext step", 32'h1, {24'h0, step});
      chk_bit("ext wave", 1'b1, dac != 10'h200);
      tick(12);
      chk("ext off", 32'h200, {22'h0, dac});
      wr(8'h10, 32'h2);
      $display("test external done");
   endtask

   // ****************************************
   // verdict, timeout and main sequence
   // ****************************************
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         test_done;
      end
   end

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      phase_in = 10'h0C0;
      phase_wrap = 1'b0;
      go = 1'b0;
      width = 8'h00;
      mismatches = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      tick(1);
      t_reset;
      t_saw;
      t_tri;
      t_burst;
      t_ext;
      test_done;
   end
endmodule
